// file: verilog/cis_pkg.sv
// package: constants for the cpu interrupt sequencer
package cis_pkg;
  localparam int NUM_SRC = 16;
  localparam int NUM_EXT = 3;
  localparam int SRC_W = 4;
  localparam int PRIO_W = 3;
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_FLAG = 8'h00;
  localparam logic [7:0] OFF_FLAG_CLR = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_PRIO_LO = 8'h0c;
  localparam logic [7:0] OFF_PRIO_HI = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_CORE_CTRL = 8'h18;
  localparam logic [7:0] OFF_INTERRUPT_CONTROL_TWO = 8'h1c;
  localparam logic [7:0] OFF_STACK_PTR = 8'h20;
  localparam logic [7:0] OFF_STACK_LIM = 8'h24;
  localparam logic [7:0] OFF_SHADOW = 8'h28;
  localparam logic [7:0] OFF_STACK_ERR = 8'h2c;
  localparam logic [7:0] OFF_VECTOR = 8'h30;
  // field positions
  localparam int CORE_TRAP_BIT = 3;
  localparam int ALT_VEC_BIT = 15;
  localparam int STAT_PRIO_LSB = 5;
  localparam int SHADOW_FLAG_W = 5;
  // vector tables: primary at base, alternate right behind it
  localparam logic [15:0] PRIMARY_VEC_BASE = 16'h0004;
  localparam logic [15:0] VEC_TABLE_WORDS = 16'h0040;
  localparam logic [15:0] VEC_STRIDE = 16'h0002;
  localparam int VEC_SRC_LSB = 1;
  localparam logic [15:0] STACK_FLOOR = 16'h0800;
  localparam logic [15:0] STACK_RESET = 16'h0800;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [3:0] SRC_ONE = 4'h1;
  localparam logic [2:0] PRIO_ZERO = 3'h0;
  localparam logic [31:0] NO_ERR = 32'h0000_0000;
  typedef enum logic [1:0] {CIS_RUN, CIS_PUSH_PC, CIS_PUSH_SR, CIS_POP} cis_state_t;
endpackage

// file: verilog/cis_edge_sync.sv
// external interrupt edge detector with three-stage synchroniser
`timescale 1ns/100ps
`default_nettype none
module cis_edge_sync
  import cis_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic pin,
  input wire logic falling,
  output logic edge_pulse
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic agreed_q;
  // s1 feeds only s2; a change counts once s2 and s3 agree on the new level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      agreed_q <= 1'b0;
    end
    else if (clk_en)
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) agreed_q <= s3_q;
    end
  end
  // settled level against the last agreed level, per polarity bit
  wire settled = clk_en & (s2_q == s3_q);
  assign edge_pulse = settled & (falling ? (agreed_q & ~s3_q) : (~agreed_q & s3_q));
endmodule
`default_nettype wire

// file: verilog/cis_top.sv
// cpu interrupt sequencer: flags, priority, stack frame, shadows, apb registers
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - event flags are captured into the flag registers every instruction cycle
// - a flag counts only when its enable bit is also set
// - interrupt only when pending priority strictly exceeds the cpu level
// - push pc and status low byte, then load the new priority level
// - new level blocks equal or lower priority until return or lowering
// - trap level bit reads clear during interrupts, set only during traps
// - return pops pc and status, restoring priority and state
// - alternate select bit makes every vector fetch use the alternate table
// - one-deep shadows of five flags and w0..w3, only via push/pop shadow
// - three external inputs are edge sensitive with per-input polarity
// - enabled sufficient-priority request during sleep or idle wakes and vectors
// - stack pointer points to free word, post-increments push, pre-decrements pop
// - call push zero-extends the pc upper byte (code pushes core_pc[7:0] with a zero upper byte)
// - exception push places status low byte in the pushed upper byte
// - stack limit not reset, bit 0 forced to zero
// - push at limit does not trap; the following push traps
// - stack address below 0x0800 raises a stack error trap
module cis_top
  import cis_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SRC-1:0] event_in,
  input wire logic [NUM_EXT-1:0] ext_irq_inputs,
  input wire logic [15:0] core_pc,
  input wire logic call_push,
  input wire logic ret_pop,
  input wire logic return_from_interrupt,
  input wire logic trap_active,
  input wire logic sleep_idle,
  input wire logic shadow_push,
  input wire logic shadow_pop,
  input wire logic [SHADOW_FLAG_W-1:0] flags_in,
  input wire logic [63:0] wregs_in,
  output logic [SHADOW_FLAG_W-1:0] shadow_flags,
  output logic [63:0] shadow_wregs,
  output logic irq_take,
  output logic [15:0] vector_addr,
  output logic wake,
  output logic stack_wr,
  output logic [15:0] stack_addr,
  output logic [15:0] stack_wdata,
  output logic stack_error
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [NUM_SRC-1:0] irq_flag_regs_q;
  logic [NUM_SRC-1:0] irq_enable_regs_q;
  logic [PRIO_W*NUM_SRC-1:0] prio_q;
  logic [7:0] status_low_byte_q;
  logic alt_vector_select_q;
  logic [NUM_EXT-1:0] ext_edge_polarity_bits_q;
  logic [15:0] stack_pointer_reg_q;
  logic [15:0] stack_limit_reg_q;
  logic [SHADOW_FLAG_W-1:0] sh_flags_q;
  logic [63:0] sh_wregs_q;
  logic [15:0] saved_pc_q;
  logic [PRIO_W-1:0] new_prio_q;
  cis_state_t state_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_take_q;
  logic [15:0] vector_q;
  logic wake_q;
  logic stack_wr_q;
  logic [15:0] stack_addr_q;
  logic [15:0] stack_wdata_q;
  logic stack_err_q;
  logic [NUM_EXT-1:0] ext_pulse;
  // external edge detectors, one per pin
  generate
    for (genvar gi = 0; gi < NUM_EXT; gi++)
    begin : g_ext
      cis_edge_sync u_edge (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .pin(ext_irq_inputs[gi]), .falling(ext_edge_polarity_bits_q[gi]),
        .edge_pulse(ext_pulse[gi]));
    end
  endgenerate
  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire apb_acc = psel & penable & ~pready_q;
  wire apb_wr = psel & penable & pready_q & pwrite; // commits at the answer edge
  wire hit_flag = paddr == OFF_FLAG;
  wire hit_clr = paddr == OFF_FLAG_CLR;
  wire hit_en = paddr == OFF_ENABLE;
  wire hit_plo = paddr == OFF_PRIO_LO;
  wire hit_phi = paddr == OFF_PRIO_HI;
  wire hit_stat = paddr == OFF_STATUS;
  wire hit_core = paddr == OFF_CORE_CTRL;
  wire hit_ic2 = paddr == OFF_INTERRUPT_CONTROL_TWO;
  wire hit_sp = paddr == OFF_STACK_PTR;
  wire hit_lim = paddr == OFF_STACK_LIM;
  wire hit_sh = paddr == OFF_SHADOW;
  wire hit_err = paddr == OFF_STACK_ERR;
  wire hit_vec = paddr == OFF_VECTOR;
  wire hit_any = hit_flag | hit_clr | hit_en | hit_plo | hit_phi | hit_stat | hit_core
    | hit_ic2 | hit_sp | hit_lim | hit_sh | hit_err | hit_vec;
  wire [PRIO_W-1:0] cpu_priority_level = status_low_byte_q[STAT_PRIO_LSB +: PRIO_W];
  wire trap_level_bit = trap_active;
  wire [15:0] core_control_reg = {12'h000, trap_level_bit, 3'h0};
  wire [15:0] interrupt_control_two = {alt_vector_select_q, 12'h000, ext_edge_polarity_bits_q};
  // ------------------------------------------------------------
  // priority resolution
  // ------------------------------------------------------------
  wire [NUM_SRC-1:0] pending = irq_flag_regs_q & irq_enable_regs_q;
  logic [PRIO_W-1:0] best_prio;
  logic [SRC_W-1:0] best_src;
  logic best_valid;
  // scan from highest index down so ties land on the lowest vector
  always_comb
  begin
    best_prio = PRIO_ZERO;
    best_src = '0;
    best_valid = 1'b0;
    for (int i = NUM_SRC-1; i >= 0; i--)
    begin
      if (pending[i] && prio_q[i*PRIO_W +: PRIO_W] >= best_prio)
      begin
        best_prio = prio_q[i*PRIO_W +: PRIO_W];
        best_src = SRC_W'(i);
        best_valid = 1'b1;
      end
    end
  end
  // stack checks gate entry and pushes
  wire pushing = (state_q != CIS_RUN && state_q != CIS_POP) | (call_push & state_q == CIS_RUN);
  wire over_lim = pushing & (stack_pointer_reg_q > stack_limit_reg_q);
  wire under = stack_pointer_reg_q < STACK_FLOOR;
  wire [15:0] sp_dec = stack_pointer_reg_q - WORD_STEP;
  wire pop_under = (ret_pop | return_from_interrupt) & (sp_dec < STACK_FLOOR);
  wire stack_fault = over_lim | under | pop_under;
  wire want_irq = best_valid & (best_prio > cpu_priority_level) & ~trap_active;
  wire take = want_irq & (state_q == CIS_RUN) & ~stack_fault;
  wire [15:0] table_base = alt_vector_select_q ? PRIMARY_VEC_BASE + VEC_TABLE_WORDS
                                               : PRIMARY_VEC_BASE;
  wire [15:0] vec_calc = table_base + ({12'h000, best_src} << VEC_SRC_LSB);
  // ------------------------------------------------------------
  // flags, enables, priorities
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_flag_regs_q <= '0;
    else if (clk_en)
      irq_flag_regs_q <= ((apb_wr & hit_clr) ? irq_flag_regs_q & ~pwdata[NUM_SRC-1:0]
                         : (apb_wr & hit_flag) ? pwdata[NUM_SRC-1:0] : irq_flag_regs_q)
                         | event_in | {{(NUM_SRC-NUM_EXT){1'b0}}, ext_pulse};
  end
  // software configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_enable_regs_q <= '0;
      prio_q <= '0;
      alt_vector_select_q <= 1'b0;
      ext_edge_polarity_bits_q <= '0;
    end
    else if (clk_en && apb_wr)
    begin
      if (hit_en) irq_enable_regs_q <= pwdata[NUM_SRC-1:0];
      if (hit_plo) prio_q[23:0] <= pwdata[23:0];
      if (hit_phi) prio_q[47:24] <= pwdata[23:0];
      if (hit_ic2) alt_vector_select_q <= pwdata[ALT_VEC_BIT];
      if (hit_ic2) ext_edge_polarity_bits_q <= pwdata[NUM_EXT-1:0];
    end
  end
  // stack limit has no reset value
  always_ff @(posedge pclk)
  begin
    if (clk_en && apb_wr && hit_lim)
      stack_limit_reg_q <= {pwdata[15:1], 1'b0};
  end
  // one-deep shadow copies
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_flags_q <= '0;
      sh_wregs_q <= '0;
    end
    else if (clk_en && shadow_push)
    begin
      sh_flags_q <= flags_in;
      sh_wregs_q <= wregs_in;
    end
  end
  // ------------------------------------------------------------
  // sequencer: stack frame, return, status
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= CIS_RUN;
      status_low_byte_q <= 8'h00;
      stack_pointer_reg_q <= STACK_RESET;
      saved_pc_q <= 16'h0000;
      new_prio_q <= PRIO_ZERO;
      stack_wr_q <= 1'b0;
      stack_addr_q <= 16'h0000;
      stack_wdata_q <= 16'h0000;
      irq_take_q <= 1'b0;
      vector_q <= 16'h0000;
      wake_q <= 1'b0;
      stack_err_q <= 1'b0;
    end
    else if (clk_en)
    begin
      stack_wr_q <= 1'b0;
      irq_take_q <= 1'b0;
      wake_q <= 1'b0;
      if (stack_fault) stack_err_q <= 1'b1;
      else if (apb_wr && hit_err) stack_err_q <= 1'b0;
      unique case (state_q)
        CIS_RUN:
        begin
          if (take)
          begin
            saved_pc_q <= core_pc;
            new_prio_q <= best_prio;
            vector_q <= vec_calc;
            state_q <= CIS_PUSH_PC;
          end
          else if (call_push && !stack_fault)
          begin
            stack_wr_q <= 1'b1;
            stack_addr_q <= stack_pointer_reg_q;
            stack_wdata_q <= {8'h00, core_pc[7:0]};
            stack_pointer_reg_q <= stack_pointer_reg_q + WORD_STEP;
          end
          else if ((ret_pop || return_from_interrupt) && !stack_fault)
          begin
            stack_pointer_reg_q <= sp_dec;
            if (return_from_interrupt) state_q <= CIS_POP;
          end
          else if (apb_wr && hit_stat)
            status_low_byte_q <= pwdata[7:0];
          else if (apb_wr && hit_sp)
            stack_pointer_reg_q <= {pwdata[15:1], 1'b0};
        end
        CIS_PUSH_PC:
        begin
          stack_wr_q <= ~stack_fault;
          stack_addr_q <= stack_pointer_reg_q;
          stack_wdata_q <= saved_pc_q;
          stack_pointer_reg_q <= stack_pointer_reg_q + WORD_STEP;
          state_q <= CIS_PUSH_SR;
        end
        CIS_PUSH_SR:
        begin
          stack_wr_q <= ~stack_fault;
          stack_addr_q <= stack_pointer_reg_q;
          stack_wdata_q <= {status_low_byte_q, saved_pc_q[15:8]};
          stack_pointer_reg_q <= stack_pointer_reg_q + WORD_STEP;
          status_low_byte_q[STAT_PRIO_LSB +: PRIO_W] <= new_prio_q;
          irq_take_q <= 1'b1;
          wake_q <= sleep_idle;
          state_q <= CIS_RUN;
        end
        CIS_POP:
        begin
          status_low_byte_q <= pwdata[15:8]; // second pop loads the status byte from pwdata[15:8]
          stack_pointer_reg_q <= sp_dec;
          state_q <= CIS_RUN;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // apb read, answer and outputs
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_flag) rd_mux = {16'h0000, irq_flag_regs_q};
    if (hit_en) rd_mux = {16'h0000, irq_enable_regs_q};
    if (hit_plo) rd_mux = {8'h00, prio_q[23:0]};
    if (hit_phi) rd_mux = {8'h00, prio_q[47:24]};
    if (hit_stat) rd_mux = {24'h000000, status_low_byte_q};
    if (hit_core) rd_mux = {16'h0000, core_control_reg};
    if (hit_ic2) rd_mux = {16'h0000, interrupt_control_two};
    if (hit_sp) rd_mux = {16'h0000, stack_pointer_reg_q};
    if (hit_lim) rd_mux = {16'h0000, stack_limit_reg_q};
    if (hit_sh) rd_mux = {11'h000, sh_flags_q, 16'h0000};
    if (hit_err) rd_mux = {31'h0, stack_err_q} | NO_ERR;
    if (hit_vec) rd_mux = {16'h0000, vector_q};
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (clk_en)
    begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc & ~hit_any;
      prdata_q <= (apb_acc & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end
  // ports come straight from the registers
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_take = irq_take_q;
  assign vector_addr = vector_q;
  assign wake = wake_q;
  assign stack_wr = stack_wr_q;
  assign stack_addr = stack_addr_q;
  assign stack_wdata = stack_wdata_q;
  assign stack_error = stack_err_q;
  assign shadow_flags = sh_flags_q;
  assign shadow_wregs = sh_wregs_q;
endmodule
`default_nettype wire

// file: sim/cis_assertions.sv
// checker for the cpu interrupt sequencer ports
`timescale 1ns/100ps
`default_nettype none
module cis_assertions
  import cis_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic call_push,
  input wire logic sleep_idle,
  input wire logic shadow_push,
  input wire logic [SHADOW_FLAG_W-1:0] flags_in,
  input wire logic [63:0] wregs_in,
  input wire logic [SHADOW_FLAG_W-1:0] shadow_flags,
  input wire logic [63:0] shadow_wregs,
  input wire logic irq_take,
  input wire logic [15:0] vector_addr,
  input wire logic wake,
  input wire logic stack_wr,
  input wire logic [15:0] stack_addr,
  input wire logic [15:0] stack_wdata,
  input wire logic stack_error
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  property p_pready_next;
    psel && penable && !pready |=> pready;
  endproperty
  a_pready_next: assert property (p_pready_next) else $error("pready late");
  property p_err_resp;
    pslverr |-> pready;
  endproperty
  a_err_resp: assert property (p_err_resp) else $error("pslverr without pready");
  // ----------------------------------------
  // stack frame and vectors
  // ----------------------------------------
  property p_call_push;
    call_push |-> ##[1:2] ((stack_wr && stack_wdata[15:8] == 8'h00) || stack_error);
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push word wrong");
  property p_irq_frame;
    irq_take |-> stack_wr && $past(stack_wr) && stack_addr == $past(stack_addr) + 16'h0002;
  endproperty
  a_irq_frame: assert property (p_irq_frame) else $error("entry frame wrong");
  property p_vector;
    irq_take |-> !vector_addr[0] && vector_addr >= 16'h0004 && vector_addr < 16'h0084;
  endproperty
  a_vector: assert property (p_vector) else $error("vector outside tables");
  property p_floor;
    stack_wr |-> stack_addr >= 16'h0800;
  endproperty
  a_floor: assert property (p_floor) else $error("push below floor");
  property p_sticky;
    stack_error && !(psel && penable && pwrite) |=> stack_error;
  endproperty
  a_sticky: assert property (p_sticky) else $error("stack error lost");
  property p_wake;
    wake |-> irq_take;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without entry");
  property p_wake_sleep;
    irq_take && $past(sleep_idle) |-> wake;
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("no wake in sleep");
  property p_shadow;
    shadow_push |=> shadow_flags == $past(flags_in) && shadow_wregs == $past(wregs_in);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow not captured");
  // main scenarios
  c_wake: cover property (irq_take && wake);
  c_err: cover property ($rose(stack_error));
  c_refuse: cover property (pslverr);
endmodule
bind cis_top cis_assertions cis_assertions_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .call_push(call_push), .sleep_idle(sleep_idle), .shadow_push(shadow_push),
  .flags_in(flags_in), .wregs_in(wregs_in), .shadow_flags(shadow_flags),
  .shadow_wregs(shadow_wregs), .irq_take(irq_take), .vector_addr(vector_addr), .wake(wake),
  .stack_wr(stack_wr), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
  .stack_error(stack_error));
`default_nettype wire

// file: sim/cis_event_src.sv
// model of the event sources and external interrupt pins
`timescale 1ns/100ps
`default_nettype none
module cis_event_src
(
  input wire logic pclk,
  input wire logic [15:0] fire,
  input wire logic [2:0] ext_lvl,
  output logic [15:0] event_in,
  output logic [2:0] ext_pins
);
  // quiet sources at start
  initial
  begin
    event_in = 16'h0000;
    ext_pins = 3'h0;
  end
  // events and pin levels follow the commands one clock later
  always @(posedge pclk)
  begin
    event_in <= fire;
    ext_pins <= ext_lvl;
  end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// testbench for the cpu interrupt sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import cis_pkg::*;
;
  typedef struct packed {logic [1:0] k; logic [31:0] v; logic [31:0] m;} cis_exp_t;
  cis_exp_t expq[$];
  int mismatches = 0;
  int checks = 0;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, call_push, trap_active, sleep_idle;
  logic shadow_push, irq_take, wake, stack_wr, stack_error;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] fire, event_in, core_pc, vector_addr, stack_addr, stack_wdata;
  logic [2:0] ext_lvl, ext_pins;
  logic [4:0] flags_in, shadow_flags, sh;
  logic [63:0] wregs_in, shadow_wregs, wv;
  always #5 pclk = ~pclk;
  cis_top cis_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_in(event_in), .ext_irq_inputs(ext_pins),
    .core_pc(core_pc), .call_push(call_push), .ret_pop(1'b0), .return_from_interrupt(1'b0),
    .trap_active(trap_active), .sleep_idle(sleep_idle), .shadow_push(shadow_push),
    .shadow_pop(1'b0), .flags_in(flags_in), .wregs_in(wregs_in), .shadow_flags(shadow_flags),
    .shadow_wregs(shadow_wregs), .irq_take(irq_take), .vector_addr(vector_addr), .wake(wake),
    .stack_wr(stack_wr), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
    .stack_error(stack_error));
  cis_event_src cis_event_src_inst (.pclk(pclk), .fire(fire), .ext_lvl(ext_lvl),
    .event_in(event_in), .ext_pins(ext_pins));
  // ----------------------------------------
  // compare and bookkeeping
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task note(input logic [1:0] k, input logic [31:0] v, input logic [31:0] m);
    expq.push_back('{k, v, m});
  endtask
  task take(input logic [1:0] k, input logic [31:0] s);
    cis_exp_t e;
    if (expq.size() == 0)
      chk({30'h0, k}, 32'hffff_ffff);
    else
    begin
      e = expq.pop_front();
      chk({30'h0, k}, {30'h0, (e.k == 2'h3) ? 2'h0 : e.k});
      chk(s & e.m, e.v & e.m);
      if (e.k == 2'h3)
        chk({31'h0, pslverr}, 32'h1);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // bus and pulse drivers
  // ----------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!pready && n < 20);
    chk(32'(n < 20), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    note(2'h0, v, m);
    apb(1'b0, a, 32'h0);
  endtask
  task push_call;
    call_push <= 1'b1;
    @(posedge pclk);
    call_push <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task drain;
    int n;
    n = 0;
    while (expq.size() != 0 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    chk(32'(expq.size()), 32'h0);
  endtask
  // watcher: takes the oldest note whenever a result shows
  always @(posedge pclk)
  begin
    if (presetn && psel && penable && pready && !pwrite)
      take(2'h0, prdata);
    if (presetn && stack_wr)
      take(2'h1, {stack_addr, stack_wdata});
    if (presetn && irq_take)
      take(2'h2, {15'h0, wake, vector_addr});
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, call_push, trap_active, sleep_idle, shadow_push} = 8'h00;
    {paddr, pwdata, fire, core_pc, ext_lvl, flags_in, wregs_in} = '0;
    void'($urandom(32'he0b7));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, OFF_STACK_LIM, 32'hfffe); // limit has no reset value
    rd(OFF_STACK_PTR, 32'h0800, 32'hffff);
    note(2'h3, 32'h0, 32'hffff_ffff);
    apb(1'b0, 8'h3c, 32'h0);
    core_pc <= 16'h8000 | 16'($urandom);
    note(2'h1, 32'h0800_0000, 32'hffff_ff00);
    push_call;
    drain;
    rd(OFF_STACK_PTR, 32'h0802, 32'hffff);
    // two sources tie at level 5 above level 2, taken while asleep
    apb(1'b1, OFF_STATUS, 32'h40);
    apb(1'b1, OFF_PRIO_LO, 32'h0016_8000);
    apb(1'b1, OFF_ENABLE, 32'h60);
    sleep_idle <= 1'b1;
    note(2'h1, 32'h0802_0000, 32'hffff_0000);
    note(2'h1, 32'h0804_4000, 32'hffff_ff00);
    note(2'h2, 32'h0001_000e, 32'h0001_ffff);
    fire <= 16'h0060;
    @(posedge pclk);
    fire <= 16'h0000;
    drain;
    sleep_idle <= 1'b0;
    rd(OFF_STATUS, 32'ha0, 32'he0);
    rd(OFF_FLAG, 32'h60, 32'h60);
    rd(OFF_CORE_CTRL, 32'h0, 32'h8);
    // equal level stays blocked, then lowering lets source 6 in via the alternate table
    apb(1'b1, OFF_INTERRUPT_CONTROL_TWO, 32'h8002);
    apb(1'b1, OFF_FLAG_CLR, 32'h20);
    note(2'h1, 32'h0806_0000, 32'hffff_0000);
    note(2'h1, 32'h0808_8000, 32'hffff_ff00);
    note(2'h2, 32'h0000_0050, 32'h0001_ffff);
    apb(1'b1, OFF_STATUS, 32'h80);
    drain;
    trap_active <= 1'b1;
    rd(OFF_CORE_CTRL, 32'h8, 32'h8);
    trap_active <= 1'b0;
    // pin 0 on rising edge, pin 1 on falling edge
    ext_lvl <= 3'b011;
    repeat (6) @(posedge pclk);
    rd(OFF_FLAG, 32'h1, 32'h7);
    ext_lvl <= 3'b000;
    repeat (6) @(posedge pclk);
    rd(OFF_FLAG, 32'h3, 32'h7);
    // limit equal to pointer: one push passes, the next traps
    apb(1'b1, OFF_STACK_LIM, 32'h080b);
    rd(OFF_STACK_LIM, 32'h080a, 32'hffff);
    note(2'h1, 32'h080a_0000, 32'hffff_ff00);
    push_call;
    drain;
    push_call;
    rd(OFF_STACK_ERR, 32'h1, 32'h1);
    chk({31'h0, stack_error}, 32'h1);
    apb(1'b1, OFF_STACK_ERR, 32'h0);
    rd(OFF_STACK_ERR, 32'h0, 32'h1);
    apb(1'b1, OFF_STACK_LIM, 32'hfffe);
    apb(1'b1, OFF_STACK_PTR, 32'h07fe);
    push_call;
    rd(OFF_STACK_ERR, 32'h1, 32'h1);
    sh = 5'($urandom);
    flags_in <= sh;
    wv = {$urandom, $urandom};
    wregs_in <= wv;
    shadow_push <= 1'b1;
    @(posedge pclk);
    shadow_push <= 1'b0;
    rd(OFF_SHADOW, {11'h0, sh, 16'h0}, 32'h001f_0000);
    chk(shadow_wregs[31:0], wv[31:0]);
    chk(shadow_wregs[63:32], wv[63:32]);
    drain;
    end_sim;
  end
  // hang guard
  initial
  begin
    #200000;
    mismatches++;
    end_sim;
  end
endmodule
`default_nettype wire
